/* File: logic/flag_status_reg.sv */
// Converter flag and status register with latched faults
`timescale 1ns/1ps
`include "flag_status_consts.svh"
module flag_status_reg #(
  parameter bit FOUR_CHANNEL = 1'b1
) (
  input  wire logic        REF_CLK_IN,
  input  wire logic        NRST_IN,
  input  wire logic        RD_STROBE_IN,
  input  wire logic [7:0]  RD_ADDR_IN,
  input  wire logic        WR_STROBE_IN,
  input  wire logic [15:0] WR_DATA_IN,
  input  wire logic [3:0]  ACTIVE_CH_IN,
  input  wire logic        SEQ_MODE_IN,
  input  wire logic [3:0]  RESULT_DONE_IN,
  input  wire logic [1:0]  FAULT_CH_IN,
  input  wire logic [5:0]  FAULT_EVENT_IN,
  input  wire logic [5:0]  FAULT_IRQ_ENABLE_IN,
  input  wire logic        RESULT_READY_IRQ_ENABLE_IN,
  output logic      [15:0] STATUS_OUT,
  output logic             INTERRUPT_OUT_N
);
  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  function automatic logic [3:0] data_read_hit(input logic rd, input logic [7:0] a);
    logic [3:0] hit;
    hit = 4'h0;
    for (int i = 0; i < `NUM_CH; i++) begin
      if (rd && a == (`DATA_ADDR_BASE + 8'(i) * `DATA_REG_STRIDE)) begin
        hit[i] = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic [3:0] variant_mask(input logic four);
    return four ? 4'hF : 4'h3;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Channel mask, event qualification
  logic [3:0] var_mask;
  logic [3:0] ch_mask;
  logic [3:0] done_ok;
  logic [3:0] data_rd;
  logic       status_rd;
  logic       fault_ch_ok;
  logic       fault_hit;
  flag_status_pkg::fault_s fault_new;

  // Write path ignored: the status word is read only
  logic unused_wr;
  assign unused_wr   = WR_STROBE_IN ^ (^WR_DATA_IN);

  // Held in a net: a function result cannot be bit-selected
  assign var_mask    = variant_mask(FOUR_CHANNEL);
  assign ch_mask     = var_mask & ACTIVE_CH_IN;
  assign done_ok     = RESULT_DONE_IN & ch_mask;
  assign data_rd     = data_read_hit(RD_STROBE_IN, RD_ADDR_IN);
  assign status_rd   = RD_STROBE_IN && RD_ADDR_IN == `STATUS_ADDR;
  assign fault_ch_ok = ch_mask[FAULT_CH_IN];
  // Faults count only from active channels and enabled types
  assign fault_new   = fault_ch_ok ? (FAULT_EVENT_IN & FAULT_IRQ_ENABLE_IN)
                                   : `FAULT_NONE;
  assign fault_hit   = |fault_new;

  ////////////////////////////////////////////////////////////////////////////
  // Pending flags
  pending_if pif ();
  assign pif.result_done = done_ok;
  assign pif.result_read = data_rd;

  pending_tracker u_pending (
    .clk_in  (REF_CLK_IN),
    .nrst_in (NRST_IN),
    .pif     (pif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Fault latch, channel field, ready flag
  flag_status_pkg::fault_s fault_q;
  flag_status_pkg::fault_s fault_d;
  flag_status_pkg::chan_t  chan_q;
  flag_status_pkg::chan_t  chan_d;
  logic       ready_q;
  logic       ready_d;
  logic [3:0] fresh_q;
  logic [3:0] fresh_d;
  logic       ready_evt;
  logic       fault_clr;
  logic       irq_n_q;
  logic       irq_n_d;
  logic [15:0] status_d;
  logic [15:0] status_q;

  always_comb begin
    fresh_d   = fresh_q | done_ok;
    ready_evt = 1'b0;
    if (flag_status_pkg::conv_mode_e'(SEQ_MODE_IN) == flag_status_pkg::MODE_SINGLE) begin
      ready_evt = |done_ok;
      fresh_d   = 4'h0;
    end else if (ch_mask != 4'h0 && (fresh_d & ch_mask) == ch_mask) begin
      ready_evt = 1'b1;
      fresh_d   = 4'h0;
    end
    // Latched faults drop on a status read or a read of the faulting channel
    fault_clr = status_rd || data_rd[chan_q];
    fault_d   = fault_clr ? `FAULT_NONE : fault_q;
    fault_d   = fault_d | fault_new;
    chan_d    = fault_hit ? FAULT_CH_IN : chan_q;
    ready_d   = (ready_q & ~status_rd) | (ready_evt & RESULT_READY_IRQ_ENABLE_IN);
    irq_n_d   = ~((|fault_d) | ready_d);
    status_d  = `STATUS_RESET;
    status_d[`BIT_CHAN_HI:`BIT_CHAN_LO] = chan_d;
    status_d[`BIT_UR]    = fault_d.underrange;
    status_d[`BIT_OR]    = fault_d.overrange;
    status_d[`BIT_WD]    = fault_d.timeout;
    status_d[`BIT_AH]    = fault_d.amp_high;
    status_d[`BIT_AL]    = fault_d.amp_low;
    status_d[`BIT_ZC]    = fault_d.zero_count;
    status_d[`BIT_READY] = ready_d;
    // Channel 0 sits at bit 3 down to channel 3 at bit 0
    for (int i = 0; i < `NUM_CH; i++) begin
      status_d[3 - i] = pif.pending[i] & var_mask[i];
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      fault_q  <= `FAULT_NONE;
      chan_q   <= `CHAN_RESET;
      ready_q  <= 1'b0;
      fresh_q  <= `PENDING_NONE;
      irq_n_q  <= 1'b1;
      status_q <= `STATUS_RESET;
    end else begin
      fault_q  <= fault_d;
      chan_q   <= chan_d;
      ready_q  <= ready_d;
      fresh_q  <= fresh_d;
      irq_n_q  <= irq_n_d;
      status_q <= status_d;
    end
  end

  // Pending bits lag the tracker by one cycle in the image
  assign STATUS_OUT      = status_q;
  assign INTERRUPT_OUT_N = irq_n_q;
endmodule // flag_status_reg

/* File: logic/flag_status_consts.svh */
// Constants for the converter flag and status register block
// Notes on behaviour
// - Two-bit field names the faulting channel
// - Faults latch until status or channel read
// - Under-range fault sets, clears on status read
// - Over-range fault sets, clears on status read
// - Timeout fault sets, clears on status read
// - Amplitude high fault sets, clears on read
// - Amplitude low fault sets, clears on read
// - Zero count fault sets, clears on read
// - Single channel: ready after one result
// - Sequential: ready after all active channels
// - Per-channel pending flags, channel 0 at bit 3
// - Two-channel variant never reports channels 2, 3
// - Under-range recorded only when its enable set
// - Ready recorded only when its enable set
`ifndef FLAG_STATUS_CONSTS_SVH
`define FLAG_STATUS_CONSTS_SVH
`define STATUS_ADDR        8'h18
`define DATA_ADDR_BASE     8'h00
`define NUM_CH             4
`define BIT_CHAN_HI        15
`define BIT_CHAN_LO        14
`define BIT_UR             13
`define BIT_OR             12
`define BIT_WD             11
`define BIT_AH             10
`define BIT_AL             9
`define BIT_ZC             8
`define BIT_READY          6
`define FAULT_NONE         6'h00
`define PENDING_NONE       4'h0
`define CHAN_RESET         2'h0
`define STATUS_RESET       16'h0000
`define DATA_REG_STRIDE    8'h02
`endif

/* File: logic/flag_status_pkg.sv */
// Types shared by the flag status block
package flag_status_pkg;
  typedef logic [1:0] chan_t;
  typedef struct packed {
    logic underrange;
    logic overrange;
    logic timeout;
    logic amp_high;
    logic amp_low;
    logic zero_count;
  } fault_s;
  typedef enum logic [0:0] {
    MODE_SINGLE     = 1'b0,
    MODE_SEQUENTIAL = 1'b1
  } conv_mode_e;
endpackage

/* File: logic/pending_if.sv */
// Interface carrying per-channel result events and pending flags
`timescale 1ns/1ps
interface pending_if;
  logic [3:0] result_done;
  logic [3:0] result_read;
  logic [3:0] pending;
  modport owner (input result_done, input result_read, output pending);
  modport user  (output result_done, output result_read, input pending);
endinterface

/* File: logic/pending_tracker.sv */
// Per-channel unread result flags
`timescale 1ns/1ps
`include "flag_status_consts.svh"
module pending_tracker (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  pending_if.owner  pif
);
  logic [3:0] pending_q;
  logic [3:0] pending_d;

  always_comb begin
    // Set wins over a read in the same cycle
    pending_d = (pending_q & ~pif.result_read) | pif.result_done;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pending_q <= `PENDING_NONE;
    end else begin
      pending_q <= pending_d;
    end
  end

  assign pif.pending = pending_q;
endmodule // pending_tracker

/* File: testbench/flag_status_props.sv */
// Checker for the flag status register
`timescale 1ns/1ps
module flag_status_props #(parameter bit FOUR_CHANNEL = 1'b1) (
  input wire logic        REF_CLK_IN,
  input wire logic        NRST_IN,
  input wire logic        RD_STROBE_IN,
  input wire logic [7:0]  RD_ADDR_IN,
  input wire logic        WR_STROBE_IN,
  input wire logic [3:0]  ACTIVE_CH_IN,
  input wire logic [3:0]  RESULT_DONE_IN,
  input wire logic [1:0]  FAULT_CH_IN,
  input wire logic [5:0]  FAULT_EVENT_IN,
  input wire logic [5:0]  FAULT_IRQ_ENABLE_IN,
  input wire logic [15:0] STATUS_OUT,
  input wire logic        INTERRUPT_OUT_N
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!NRST_IN);
  logic [5:0] ev;
  logic [5:0] ev_q;
  logic       rd0;
  // Only enabled faults from a present, active channel count
  assign ev = FAULT_EVENT_IN & FAULT_IRQ_ENABLE_IN & {6{ACTIVE_CH_IN[FAULT_CH_IN]
    && (FOUR_CHANNEL || !FAULT_CH_IN[1])}};
  assign rd0 = RD_STROBE_IN && RD_ADDR_IN == 8'h00;
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) ev_q <= 6'h00;
    else ev_q <= ev;
  end
  ////////////////////////////////////////////////////////////////////////////////
  fault_latch_a: assert property (ev != 6'h00 |=> (STATUS_OUT[13:8] & ev_q) == ev_q)
    else $error("fault not latched");
  fault_chan_a: assert property (ev != 6'h00 |=> STATUS_OUT[15:14] == $past(FAULT_CH_IN))
    else $error("wrong fault channel");
  read_clear_a: assert property (RD_STROBE_IN && RD_ADDR_IN == 8'h18 && FAULT_EVENT_IN == 6'h00
    && RESULT_DONE_IN == 4'h0 |=> STATUS_OUT[13:6] == 8'h00) else $error("read left flags");
  mask_hold_a: assert property (FAULT_EVENT_IN != 6'h00 && FAULT_IRQ_ENABLE_IN == 6'h00
    && !RD_STROBE_IN |=> $stable(STATUS_OUT[13:8])) else $error("masked fault recorded");
  rsvd_zero_a: assert property (STATUS_OUT[7] == 1'b0 && STATUS_OUT[5:4] == 2'h0)
    else $error("reserved bit set");
  irq_pin_a: assert property (INTERRUPT_OUT_N == !(|STATUS_OUT[13:6]))
    else $error("interrupt pin mismatch");
  absent_ch_a: assert property (!FOUR_CHANNEL |-> STATUS_OUT[15] == 1'b0
    && STATUS_OUT[1:0] == 2'h0) else $error("absent channel reported");
  pending_set_a: assert property (RESULT_DONE_IN[0] && ACTIVE_CH_IN[0] && !rd0 ##1 !rd0
    |=> STATUS_OUT[3]) else $error("pending flag missing");
  write_ign_a: assert property (WR_STROBE_IN && !RD_STROBE_IN && FAULT_EVENT_IN == 6'h00
    && RESULT_DONE_IN == 4'h0 |=> $stable(STATUS_OUT[15:8])) else $error("write changed status");
  cover property (ev != 6'h00 ##1 STATUS_OUT[13:8] != 6'h00);
  cover property (STATUS_OUT[6] ##[1:20] !STATUS_OUT[6]);
  cover property (STATUS_OUT[3] ##[1:20] !STATUS_OUT[3]);
endmodule // flag_status_props
bind flag_status_reg flag_status_props #(.FOUR_CHANNEL(FOUR_CHANNEL)) flag_status_props_inst (
  .REF_CLK_IN(REF_CLK_IN), .NRST_IN(NRST_IN), .RD_STROBE_IN(RD_STROBE_IN),
  .RD_ADDR_IN(RD_ADDR_IN), .WR_STROBE_IN(WR_STROBE_IN), .ACTIVE_CH_IN(ACTIVE_CH_IN),
  .RESULT_DONE_IN(RESULT_DONE_IN), .FAULT_CH_IN(FAULT_CH_IN), .FAULT_EVENT_IN(FAULT_EVENT_IN),
  .FAULT_IRQ_ENABLE_IN(FAULT_IRQ_ENABLE_IN), .STATUS_OUT(STATUS_OUT),
  .INTERRUPT_OUT_N(INTERRUPT_OUT_N));

/* File: testbench/host_model.sv */
// Host side model issuing register reads and writes
`timescale 1ns/1ps
module host_model (
  input  wire logic   clk_in,
  output logic        rd_strobe_out,
  output logic [7:0]  rd_addr_out,
  output logic        wr_strobe_out,
  output logic [15:0] wr_data_out
);
  initial begin
    rd_strobe_out = 1'b0;
    rd_addr_out = 8'hFF;
    wr_strobe_out = 1'b0;
    wr_data_out = 16'h0000;
  end
  // Idle bus shows an unmapped address, never the stale one
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    rd_strobe_out <= 1'b1;
    rd_addr_out <= a;
    @(posedge clk_in);
    rd_strobe_out <= 1'b0;
    rd_addr_out <= 8'hFF;
  endtask
  task automatic wr(input logic [15:0] d);
    @(posedge clk_in);
    wr_strobe_out <= 1'b1;
    wr_data_out <= d;
    @(posedge clk_in);
    wr_strobe_out <= 1'b0;
    wr_data_out <= ~d;
  endtask
endmodule // host_model

/* File: testbench/converter_error_status_flags_tb.sv */
// Self-checking bench for the flag status register
`timescale 1ns/1ps
module converter_error_status_flags_tb;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [3:0]  active = 4'hF;
  logic        seq = 1'b0;
  logic [3:0]  done = 4'h0;
  logic [1:0]  fch = 2'h0;
  logic [5:0]  fev = 6'h00;
  logic [5:0]  fen = 6'h3F;
  logic        rren = 1'b1;
  logic [15:0] st;
  logic        int_n;
  logic        rd;
  logic        wr;
  logic [7:0]  ra;
  logic [15:0] wd;
  int          err_count = 0;
  int          cmp_count = 0;
  always #25 clk = ~clk;
  flag_status_reg flag_status_reg_inst (.REF_CLK_IN(clk), .NRST_IN(nrst), .RD_STROBE_IN(rd),
    .RD_ADDR_IN(ra), .WR_STROBE_IN(wr), .WR_DATA_IN(wd), .ACTIVE_CH_IN(active),
    .SEQ_MODE_IN(seq), .RESULT_DONE_IN(done), .FAULT_CH_IN(fch), .FAULT_EVENT_IN(fev),
    .FAULT_IRQ_ENABLE_IN(fen), .RESULT_READY_IRQ_ENABLE_IN(rren), .STATUS_OUT(st),
    .INTERRUPT_OUT_N(int_n));
  host_model host_model_inst (.clk_in(clk), .rd_strobe_out(rd), .rd_addr_out(ra),
    .wr_strobe_out(wr), .wr_data_out(wd));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic fire(input logic [1:0] c, input logic [5:0] e, input logic [3:0] d);
    @(posedge clk);
    fch <= c;
    fev <= e;
    done <= d;
    @(posedge clk);
    fev <= 6'h00;
    done <= 4'h0;
    @(negedge clk);
  endtask
  task automatic rdl(input logic [7:0] a);
    host_model_inst.rd(a);
    // Pending bits reach the image one cycle after the read
    repeat (2) @(negedge clk);
  endtask
  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (19) @(posedge clk);
    @(negedge clk);
    chk({int_n, st[14:0]}, 16'h8000);
    @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      fire(2'(i % 4), 6'h01 << i, 4'h0);
      chk({st[15:8], 7'h00, int_n}, {2'(i % 4), 6'h01 << i, 8'h00});
      rdl(8'h18);
      chk({st[15:1], int_n}, {2'(i % 4), 14'h0001});
    end
    fire(2'h2, 6'h20, 4'h0);
    rdl(8'h00);
    chk(st, 16'hA000);
    rdl(8'h04);
    chk(st, 16'h8000);
    $display("fault tests done");
    fen <= 6'h00;
    rren <= 1'b0;
    fire(2'h1, 6'h3F, 4'h1);
    chk(st & 16'hFFF0, 16'h8000);
    fen <= 6'h3F;
    active <= 4'hE;
    fire(2'h0, 6'h3F, 4'h0);
    chk(st & 16'hFFF0, 16'h8000);
    rdl(8'h00);
    chk(st, 16'h8000);
    active <= 4'hF;
    rren <= 1'b1;
    fire(2'h0, 6'h00, 4'h1);
    chk(st & 16'hFFF0, 16'h8040);
    @(negedge clk);
    chk(st, 16'h8048);
    rdl(8'h18);
    chk(st, 16'h8008);
    rdl(8'h00);
    chk(st, 16'h8000);
    seq <= 1'b1;
    active <= 4'h3;
    fire(2'h0, 6'h00, 4'h1);
    chk(st & 16'h0040, 16'h0000);
    fire(2'h0, 6'h00, 4'h2);
    chk(st & 16'h0040, 16'h0040);
    rdl(8'h30);
    chk(st, 16'h804C);
    host_model_inst.wr(16'hFFFF);
    @(negedge clk);
    chk(st, 16'h804C);
    $display("ready tests done");
    wrap_up();
  end
endmodule // converter_error_status_flags_tb
